// >>> hw/msrb_bank.sv
// Device-specific special function register bank of the MPU core
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
module msrb_bank
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output      logic [7:0]  sfr_rdata,
  output      logic        sfr_hit,
  input  wire logic        xmem_start,
  input  wire logic        xmem_is_write,
  input  wire logic        xmem_via_data_pointer,
  output      logic        xmem_busy,
  output      logic        xmem_addr_phase,
  output      logic        xmem_rd_strobe,
  output      logic        xmem_wr_strobe,
  output      logic        xmem_done,
  output      logic        xmem_to_flash,
  output      logic [7:0]  ee_data_out,
  output      logic [7:0]  ee_ctrl_out,
  output      logic        ee_ctrl_wr,
  input  wire logic [7:0]  ee_data_in,
  input  wire logic [7:0]  ee_status_in,
  output      logic        mass_erase_start,
  output      logic        page_erase_start,
  output      logic [6:0]  erase_page,
  output      logic [2:0]  flash_bank,
  output      logic        secure_lock,
  output      logic        ext_read_block,
  input  wire logic        preboot_active,
  input  wire logic        transfer_busy_event,
  input  wire logic        one_second_tick,
  input  wire logic        flash_write_active,
  input  wire logic        engine_busy,
  input  wire logic        engine_pass_start,
  input  wire logic        pushbutton_press,
  input  wire logic        autowake_event,
  input  wire logic        pll_rise_event,
  input  wire logic        pll_fall_event,
  input  wire logic [6:0]  external_irq_levels,
  output      logic        watchdog_restart
);

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for asynchronous inputs

  logic [6:0] irq_meta_reg;
  logic [6:0] irq_sync_reg;
  logic       pb_meta_reg;
  logic       pb_sync_reg;
  logic       pre_meta_reg;
  logic       pre_sync_reg;

  // Stages reset low, the idle level of these pins
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_meta_reg <= 7'h00;
      irq_sync_reg <= 7'h00;
      pb_meta_reg  <= 1'b0;
      pb_sync_reg  <= 1'b0;
      pre_meta_reg <= 1'b0;
      pre_sync_reg <= 1'b0;
    end
    else
    begin
      irq_meta_reg <= external_irq_levels;
      irq_sync_reg <= irq_meta_reg;
      pb_meta_reg  <= pushbutton_press;
      pb_sync_reg  <= pb_meta_reg;
      pre_meta_reg <= preboot_active;
      pre_sync_reg <= pre_meta_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic logic wr_at(input logic [7:0] a, input logic w, input logic [7:0] off);
    wr_at = w && (a == off);
  endfunction

  logic wr_stretch;
  logic wr_erase;
  logic wr_eed;
  logic wr_eec;
  logic wr_fctl;
  logic wr_bank;
  logic wr_page;
  logic wr_flags;
  logic wr_iw;

  assign wr_stretch = wr_at(sfr_addr, sfr_wr, msrb_pkg::ADDR_STRETCH);
  assign wr_erase   = wr_at(sfr_addr, sfr_wr, msrb_pkg::ADDR_ERASE_TRIG);
  assign wr_eed     = wr_at(sfr_addr, sfr_wr, msrb_pkg::ADDR_EE_DATA);
  assign wr_eec     = wr_at(sfr_addr, sfr_wr, msrb_pkg::ADDR_EE_CTRL);
  assign wr_fctl    = wr_at(sfr_addr, sfr_wr, msrb_pkg::ADDR_FLASH_CTRL);
  assign wr_bank    = wr_at(sfr_addr, sfr_wr, msrb_pkg::ADDR_BANK_SEL);
  assign wr_page    = wr_at(sfr_addr, sfr_wr, msrb_pkg::ADDR_PAGE_ADDR);
  assign wr_flags   = wr_at(sfr_addr, sfr_wr, msrb_pkg::ADDR_EVENT_FLAGS);
  assign wr_iw      = wr_at(sfr_addr, sfr_wr, msrb_pkg::ADDR_INPUT_WDOG);

  //////////////////////////////////////////////////////////////////////////
  // Control registers

  logic [2:0] stretch_reg;
  logic [2:0] stretch_next;
  logic [7:0] eed_reg;
  logic [7:0] eed_next;
  logic [7:0] eec_reg;
  logic [7:0] eec_next;
  logic       pwe_reg;
  logic       pwe_next;
  logic       meen_reg;
  logic       meen_next;
  logic       secure_reg;
  logic       secure_next;
  logic [2:0] bank_reg;
  logic [2:0] bank_next;
  logic [7:0] page_reg;
  logic [7:0] page_next;
  logic       mass_reg;
  logic       mass_next;
  logic       pgers_reg;
  logic       pgers_next;
  logic       wdog_reg;
  logic       wdog_next;

  always_comb
  begin
    stretch_next = stretch_reg;
    eed_next     = eed_reg;
    eec_next     = eec_reg;
    pwe_next     = pwe_reg;
    meen_next    = meen_reg;
    secure_next  = secure_reg;
    bank_next    = bank_reg;
    page_next    = page_reg;
    mass_next    = 1'b0;
    pgers_next   = 1'b0;
    wdog_next    = 1'b0;
    if (wr_stretch)
      stretch_next = sfr_wdata[2:0];
    if (wr_eed)
      eed_next = sfr_wdata;
    if (wr_eec)
      eec_next = sfr_wdata;
    if (wr_bank)
      bank_next = sfr_wdata[2:0];
    // Erase engine takes the page during the pulse; clear it afterwards
    if (pgers_reg)
    begin
      page_next = msrb_pkg::PAGE_ADDR_RESET;
    end
    if (wr_page)
      page_next = sfr_wdata & msrb_pkg::PAGE_LAST;
    if (wr_fctl)
    begin
      pwe_next = sfr_wdata[msrb_pkg::FC_PWE];
      meen_next = sfr_wdata[msrb_pkg::FC_MEEN];
      if (sfr_wdata[msrb_pkg::FC_SECURE])
        secure_next = 1'b1;
    end
    if (wr_erase)
    begin
      // Mass erase when armed, else page erase
      if (meen_reg)
      begin
        mass_next = 1'b1;
        meen_next = 1'b0;
      end
      else
      begin
        pgers_next = 1'b1;
      end
    end
    if (wr_iw && sfr_wdata[msrb_pkg::IW_WDOG])
      wdog_next = 1'b1;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      stretch_reg <= msrb_pkg::STRETCH_RESET;
      eed_reg     <= 8'h00;
      eec_reg     <= 8'h00;
      pwe_reg     <= 1'b0;
      meen_reg    <= 1'b0;
      secure_reg  <= 1'b0;
      bank_reg    <= 3'h0;
      page_reg    <= msrb_pkg::PAGE_ADDR_RESET;
      mass_reg    <= 1'b0;
      pgers_reg   <= 1'b0;
      wdog_reg    <= 1'b0;
    end
    else
    begin
      stretch_reg <= stretch_next;
      eed_reg     <= eed_next;
      eec_reg     <= eec_next;
      pwe_reg     <= pwe_next;
      meen_reg    <= meen_next;
      secure_reg  <= secure_next;
      bank_reg    <= bank_next;
      page_reg    <= page_next;
      mass_reg    <= mass_next;
      pgers_reg   <= pgers_next;
      wdog_reg    <= wdog_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Event flags; a hardware set beats a software clear

  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] flag_set;
  logic       pb_prev_reg;
  logic       pb_prev_next;

  always_comb
  begin
    flag_set = 8'h00;
    flag_set[msrb_pkg::FL_XFER] = transfer_busy_event;
    flag_set[msrb_pkg::FL_RTC]  = one_second_tick;
    flag_set[msrb_pkg::FL_COL1] = flash_write_active && engine_busy;
    flag_set[msrb_pkg::FL_COL0] = flash_write_active && engine_pass_start;
    // Pushbutton flag sets on the synchronised rising edge only
    flag_set[msrb_pkg::FL_PB]   = pb_sync_reg && !pb_prev_reg;
    flag_set[msrb_pkg::FL_WAKE] = autowake_event;
    flag_set[msrb_pkg::FL_PLLR] = pll_rise_event;
    flag_set[msrb_pkg::FL_PLLF] = pll_fall_event;
    pb_prev_next = pb_sync_reg;
    flags_next = flags_reg;
    // Ones written are ignored, zeros clear
    if (wr_flags)
      flags_next = flags_reg & sfr_wdata;
    flags_next = flags_next | flag_set;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      flags_reg   <= 8'h00;
      pb_prev_reg <= 1'b0;
    end
    else
    begin
      flags_reg   <= flags_next;
      pb_prev_reg <= pb_prev_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read mux, combinational in the same access

  always_comb
  begin
    sfr_rdata = 8'h00;
    sfr_hit   = 1'b1;
    case (sfr_addr)
      msrb_pkg::ADDR_STRETCH:     sfr_rdata = {5'h00, stretch_reg};
      msrb_pkg::ADDR_EE_DATA:     sfr_rdata = ee_data_in;
      msrb_pkg::ADDR_EE_CTRL:     sfr_rdata = ee_status_in;
      msrb_pkg::ADDR_FLASH_CTRL:
        sfr_rdata = {pre_sync_reg, secure_reg, 5'h00, pwe_reg};
      msrb_pkg::ADDR_BANK_SEL:    sfr_rdata = {5'h00, bank_reg};
      msrb_pkg::ADDR_PAGE_ADDR:   sfr_rdata = page_reg;
      msrb_pkg::ADDR_EVENT_FLAGS: sfr_rdata = flags_reg;
      msrb_pkg::ADDR_INPUT_WDOG:  sfr_rdata = {1'b0, irq_sync_reg};
      msrb_pkg::ADDR_ERASE_TRIG:  sfr_rdata = 8'h00;
      default:                    sfr_hit   = 1'b0;
    endcase
    if (!sfr_rd)
      sfr_rdata = 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////
  // External data memory sequencing

  msrb_mem_if mem_if ();

  assign mem_if.start    = xmem_start;
  assign mem_if.is_write = xmem_is_write;
  assign mem_if.stretch  = stretch_reg;

  msrb_xmem_seq u_seq
  (
    .sys_clk (sys_clk),
    .rst     (rst),
    .mem     (mem_if.seq)
  );

  assign xmem_busy       = mem_if.busy;
  assign xmem_addr_phase = mem_if.addr_phase;
  assign xmem_rd_strobe  = mem_if.rd_strobe;
  assign xmem_wr_strobe  = mem_if.wr_strobe;
  assign xmem_done       = mem_if.done;
  // Flash route follows the current store, not a latched copy
  assign xmem_to_flash   = pwe_reg && xmem_is_write && xmem_via_data_pointer;

  assign ee_data_out      = eed_reg;
  assign ee_ctrl_out      = eec_reg;
  assign ee_ctrl_wr       = wr_eec;
  assign mass_erase_start = mass_reg;
  assign page_erase_start = pgers_reg;
  assign erase_page       = page_reg[6:0];
  assign flash_bank       = bank_reg;
  assign secure_lock      = secure_reg;
  assign ext_read_block   = secure_reg;
  assign watchdog_restart = wdog_reg;

endmodule

// >>> hw/msrb_mem_if.sv
// Interface between the bank and its external data memory strobe sequencer
`timescale 1ns/1ps
interface msrb_mem_if;
  logic       start;
  logic       is_write;
  logic [2:0] stretch;
  logic       busy;
  logic       addr_phase;
  logic       rd_strobe;
  logic       wr_strobe;
  logic       done;

  modport bank (output start, output is_write, output stretch,
                input busy, input addr_phase, input rd_strobe, input wr_strobe, input done);
  modport seq  (input start, input is_write, input stretch,
                output busy, output addr_phase, output rd_strobe, output wr_strobe,
                output done);
endinterface

// >>> hw/msrb_pkg.sv
// Package with offsets, field positions and reset values of the special register bank
package msrb_pkg;

  localparam logic [7:0] ADDR_STRETCH     = 8'h8E;
  localparam logic [7:0] ADDR_ERASE_TRIG  = 8'h94;
  localparam logic [7:0] ADDR_EE_DATA     = 8'h9E;
  localparam logic [7:0] ADDR_EE_CTRL     = 8'h9F;
  localparam logic [7:0] ADDR_FLASH_CTRL  = 8'hB2;
  localparam logic [7:0] ADDR_BANK_SEL    = 8'hB6;
  localparam logic [7:0] ADDR_PAGE_ADDR   = 8'hB7;
  localparam logic [7:0] ADDR_EVENT_FLAGS = 8'hE8;
  localparam logic [7:0] ADDR_INPUT_WDOG  = 8'hF8;

  localparam logic [2:0] STRETCH_RESET    = 3'h1;
  localparam logic [7:0] PAGE_ADDR_RESET  = 8'h00;
  localparam logic [7:0] PAGE_LAST        = 8'h7F;

  localparam int FC_PWE    = 0;
  localparam int FC_MEEN   = 1;
  localparam int FC_SECURE = 6;
  localparam int FC_PREBT  = 7;

  localparam int FL_XFER   = 0;
  localparam int FL_RTC    = 1;
  localparam int FL_COL1   = 2;
  localparam int FL_COL0   = 3;
  localparam int FL_PB     = 4;
  localparam int FL_WAKE   = 5;
  localparam int FL_PLLR   = 6;
  localparam int FL_PLLF   = 7;

  localparam int IW_WDOG   = 7;

  typedef enum logic [3:0] {
    MX_IDLE  = 4'b0001,
    MX_ADDR  = 4'b0010,
    MX_STRB  = 4'b0100,
    MX_DONE  = 4'b1000
  } msrb_mx_state_t;

endpackage

// >>> hw/msrb_xmem_seq.sv
// Strobe sequencer for stretched external data memory cycles
`timescale 1ns/1ps
module msrb_xmem_seq
(
  input  wire logic   sys_clk,
  input  wire logic   rst,
  msrb_mem_if.seq     mem
);

  msrb_pkg::msrb_mx_state_t state_reg;
  msrb_pkg::msrb_mx_state_t state_next;
  logic [3:0]               cnt_reg;
  logic [3:0]               cnt_next;
  logic                     wr_reg;
  logic                     wr_next;
  logic [3:0]               s_ext;

  assign s_ext = {1'b0, mem.stretch};

  // Strobe length: read s+1, write 1 for s<2 else s
  function automatic logic [3:0] strobe_len(input logic w, input logic [3:0] s);
    if (!w)
      strobe_len = s + 4'h1;
    else if (s < 4'h2)
      strobe_len = 4'h1;
    else
      strobe_len = s;
  endfunction

  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    wr_next    = wr_reg;
    case (state_reg)
      msrb_pkg::MX_IDLE:
      begin
        if (mem.start)
        begin
          state_next = msrb_pkg::MX_ADDR;
          wr_next    = mem.is_write;
          // Address phase overlaps strobe; count address-only lead cycles
          // Read: address s+1 = strobe s+1, lead 0; write: s+2 vs strobe
          cnt_next   = mem.is_write ? (s_ext + 4'h2 - strobe_len(1'b1, s_ext)) : 4'h0;
          if (!mem.is_write)
          begin
            state_next = msrb_pkg::MX_STRB;
            cnt_next   = strobe_len(1'b0, s_ext);
          end
        end
      end
      msrb_pkg::MX_ADDR:
      begin
        if (cnt_reg <= 4'h1)
        begin
          state_next = msrb_pkg::MX_STRB;
          cnt_next   = strobe_len(1'b1, s_ext);
        end
        else
          cnt_next = cnt_reg - 4'h1;
      end
      msrb_pkg::MX_STRB:
      begin
        if (cnt_reg <= 4'h1)
          state_next = msrb_pkg::MX_DONE;
        else
          cnt_next = cnt_reg - 4'h1;
      end
      msrb_pkg::MX_DONE:
        state_next = msrb_pkg::MX_IDLE;
      default:
        state_next = msrb_pkg::MX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= msrb_pkg::MX_IDLE;
      cnt_reg   <= 4'h0;
      wr_reg    <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      wr_reg    <= wr_next;
    end
  end

  assign mem.busy       = (state_reg != msrb_pkg::MX_IDLE);
  assign mem.addr_phase = (state_reg == msrb_pkg::MX_ADDR) || (state_reg == msrb_pkg::MX_STRB);
  assign mem.rd_strobe  = (state_reg == msrb_pkg::MX_STRB) && !wr_reg;
  assign mem.wr_strobe  = (state_reg == msrb_pkg::MX_STRB) && wr_reg;
  assign mem.done       = (state_reg == msrb_pkg::MX_DONE);

endmodule

// >>> verif/msrb_bank_chk.sv
// Port checker for the special function register bank
`timescale 1ns/1ps
module msrb_bank_chk
(
  input logic       sys_clk,
  input logic       rst,
  input logic [7:0] sfr_addr,
  input logic       sfr_wr,
  input logic       sfr_rd,
  input logic [7:0] sfr_wdata,
  input logic [7:0] sfr_rdata,
  input logic       xmem_addr_phase,
  input logic       xmem_rd_strobe,
  input logic       xmem_wr_strobe,
  input logic       xmem_done,
  input logic       mass_erase_start,
  input logic       page_erase_start,
  input logic       secure_lock,
  input logic       ext_read_block,
  input logic [6:0] external_irq_levels,
  input logic       watchdog_restart
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic [2:0] str_reg;
  logic [2:0] str_next;
  logic [3:0] rdn_reg;
  logic [3:0] rdn_next;
  logic [3:0] wrn_reg;
  logic [3:0] wrn_next;

  // Shadow of the stretch field and strobe widths
  always_comb
  begin
    str_next = str_reg;
    if (sfr_wr && sfr_addr == msrb_pkg::ADDR_STRETCH)
    begin
      str_next = sfr_wdata[2:0];
    end
    rdn_next = xmem_rd_strobe ? rdn_reg + 4'h1 : 4'h0;
    wrn_next = xmem_wr_strobe ? wrn_reg + 4'h1 : 4'h0;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      str_reg <= msrb_pkg::STRETCH_RESET;
      rdn_reg <= 4'h0;
      wrn_reg <= 4'h0;
    end
    else
    begin
      str_reg <= str_next;
      rdn_reg <= rdn_next;
      wrn_reg <= wrn_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  rd_width_a:
    assert property ($fell(xmem_rd_strobe) |-> rdn_reg == {1'b0, str_reg} + 4'h1)
    else $error("read strobe width wrong");
  wr_width_a:
    assert property ($fell(xmem_wr_strobe) |->
      wrn_reg == ((str_reg < 3'h2) ? 4'h1 : {1'b0, str_reg}))
    else $error("write strobe width wrong");
  wr_end_a:
    assert property ($fell(xmem_wr_strobe) |-> $fell(xmem_addr_phase))
    else $error("write strobe not aligned to address end");
  done_pulse_a:
    assert property ($fell(xmem_addr_phase) |-> xmem_done ##1 !xmem_done)
    else $error("done not a single pulse after address phase");
  erase_cause_a:
    assert property (mass_erase_start || page_erase_start |->
      $past(sfr_wr) && $past(sfr_addr) == msrb_pkg::ADDR_ERASE_TRIG)
    else $error("erase start without trigger write");
  mass_once_a:
    assert property (mass_erase_start |-> !page_erase_start ##1 !mass_erase_start)
    else $error("mass erase pulse malformed");
  secure_hold_a:
    assert property (secure_lock |=> secure_lock)
    else $error("security bit cleared");
  secure_set_a:
    assert property (sfr_wr && sfr_addr == msrb_pkg::ADDR_FLASH_CTRL && sfr_wdata[6]
      |=> secure_lock)
    else $error("security bit not set");
  read_block_a:
    assert property (ext_read_block == secure_lock)
    else $error("read block differs from security bit");
  trig_read_a:
    assert property (sfr_rd && sfr_addr == msrb_pkg::ADDR_ERASE_TRIG |-> sfr_rdata == 8'h00)
    else $error("erase trigger read not zero");
  irq_live_a:
    assert property (sfr_rd && sfr_addr == msrb_pkg::ADDR_INPUT_WDOG && !$past(rst)
      && !$past(rst, 2) |-> sfr_rdata == {1'b0, $past(external_irq_levels, 2)})
    else $error("interrupt level readback wrong");
  wdog_pulse_a:
    assert property (sfr_wr && sfr_addr == msrb_pkg::ADDR_INPUT_WDOG && sfr_wdata[7]
      |=> watchdog_restart ##1 !watchdog_restart)
    else $error("watchdog restart pulse wrong");
endmodule

bind msrb_bank msrb_bank_chk u_chk (
  .sys_clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
  .xmem_addr_phase, .xmem_rd_strobe, .xmem_wr_strobe, .xmem_done,
  .mass_erase_start, .page_erase_start, .secure_lock, .ext_read_block,
  .external_irq_levels, .watchdog_restart);

// >>> verif/msrb_mpu_model.sv
// MPU core side of the special function register bus
`timescale 1ns/1ps
module msrb_mpu_model
(
  input  logic       sys_clk,
  output logic [7:0] sfr_addr,
  output logic       sfr_wr,
  output logic       sfr_rd,
  output logic [7:0] sfr_wdata
);
  initial
  begin
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
  end

  // Released strobes go low; address and data lines show the inverse of their last value
  task automatic release_bus();
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = ~sfr_addr;
    sfr_wdata = ~sfr_wdata;
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge sys_clk);
    release_bus();
  endtask

  task automatic bus_rd(input logic [7:0] a);
    @(negedge sys_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge sys_clk);
    release_bus();
  endtask

  // Whole-byte mask, zero only where a flag is cleared
  task automatic flag_clear(input logic [7:0] bits);
    bus_wr(msrb_pkg::ADDR_EVENT_FLAGS, ~bits);
  endtask

  task automatic keep_stretch();
    bus_wr(msrb_pkg::ADDR_STRETCH, 8'h01);
  endtask
endmodule

// >>> verif/test_mpu_special_register_bank.sv
// Testbench of the special function register bank
`timescale 1ns/1ps
module test_mpu_special_register_bank;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] sfr_addr;
  logic       sfr_wr;
  logic       sfr_rd;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic       sfr_hit;
  logic       xmem_busy;
  logic       ee_ctrl_wr;
  int         ecw = 0;
  logic       xmem_start = 1'b0;
  logic       xmem_is_write = 1'b0;
  logic       xmem_via_data_pointer = 1'b0;
  logic       xmem_addr_phase;
  logic       xmem_rd_strobe;
  logic       xmem_wr_strobe;
  logic       xmem_done;
  logic       xmem_to_flash;
  logic [7:0] ee_data_out;
  logic [7:0] ee_ctrl_out;
  logic [7:0] ee_data_in = 8'h00;
  logic [7:0] ee_status_in = 8'h00;
  logic       mass_erase_start;
  logic       page_erase_start;
  logic [6:0] erase_page;
  logic [2:0] flash_bank;
  logic       secure_lock;
  logic       ext_read_block;
  logic       preboot_active = 1'b0;
  logic [7:0] ev = 8'h00;
  logic [6:0] external_irq_levels = 7'h00;
  logic       watchdog_restart;
  int         err_count = 0;
  int         tests_run = 0;
  integer     seed = 32'h0b5b_c33c;
  logic [7:0] exq[$];
  logic [7:0] v;
  int         i;

  always #4 sys_clk = ~sys_clk;

  msrb_bank dut (
    .sys_clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .sfr_hit,
    .xmem_start, .xmem_is_write, .xmem_via_data_pointer, .xmem_busy, .xmem_addr_phase,
    .xmem_rd_strobe, .xmem_wr_strobe, .xmem_done, .xmem_to_flash, .ee_data_out,
    .ee_ctrl_out, .ee_ctrl_wr, .ee_data_in, .ee_status_in, .mass_erase_start,
    .page_erase_start, .erase_page, .flash_bank, .secure_lock, .ext_read_block,
    .preboot_active, .transfer_busy_event(ev[0]), .one_second_tick(ev[1]),
    .flash_write_active(ev[2] | ev[3]), .engine_busy(ev[2]), .engine_pass_start(ev[3]),
    .pushbutton_press(ev[4]), .autowake_event(ev[5]), .pll_rise_event(ev[6]),
    .pll_fall_event(ev[7]), .external_irq_levels, .watchdog_restart);

  msrb_mpu_model mpu (.sys_clk, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata);

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exq.push_back(e);
    mpu.bus_rd(a);
  endtask

  task automatic xacc(input logic w, input logic [2:0] s);
    int na = 0;
    int nr = 0;
    int nw = 0;
    @(negedge sys_clk);
    xmem_is_write = w;
    xmem_start = 1'b1;
    @(negedge sys_clk);
    xmem_start = 1'b0;
    for (int k = 0; k < 20 && xmem_done !== 1'b1; k++)
    begin
      na += xmem_addr_phase;
      nr += xmem_rd_strobe;
      nw += xmem_wr_strobe;
      @(negedge sys_clk);
    end
    chk(8'(na), w ? 8'(s) + 8'h02 : 8'(s) + 8'h01);
    chk(8'(nr), w ? 8'h00 : 8'(s) + 8'h01);
    chk(8'(nw), !w ? 8'h00 : (s < 3'h2) ? 8'h01 : 8'(s));
    chk(8'({xmem_busy, xmem_done}), 8'h03);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Read data monitor
  always @(posedge sys_clk)
  begin
    if (sfr_rd === 1'b1 && exq.size() > 0)
    begin
      chk(sfr_rdata, exq.pop_front());
      chk(8'(sfr_hit), 8'(sfr_addr != 8'h80));
    end
  end

  // Count write strobes seen on the control register
  always @(posedge sys_clk)
  begin
    if (ee_ctrl_wr === 1'b1)
      ecw++;
  end

  initial
  begin
    #100000;
    err_count++;
    $display("[FAIL] %0t run timed out", $time);
    results();
  end

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    rd(msrb_pkg::ADDR_STRETCH, 8'h01);
    rd(msrb_pkg::ADDR_PAGE_ADDR, msrb_pkg::PAGE_ADDR_RESET);
    rd(msrb_pkg::ADDR_FLASH_CTRL, 8'h00);
    rd(8'h80, 8'h00);
    xacc(1'b0, msrb_pkg::STRETCH_RESET);
    $display("test reset done");
    for (i = 0; i < 8; i++)
    begin
      v = {8'($random(seed))};
      v[2:0] = 3'(i);
      mpu.bus_wr(msrb_pkg::ADDR_STRETCH, v);
      rd(msrb_pkg::ADDR_STRETCH, {5'h00, v[2:0]});
      xacc(1'b0, 3'(i));
      xacc(1'b1, 3'(i));
    end
    mpu.keep_stretch();
    $display("test stretch done");
    xmem_via_data_pointer = 1'b1;
    mpu.bus_wr(msrb_pkg::ADDR_FLASH_CTRL, 8'h43);
    rd(msrb_pkg::ADDR_FLASH_CTRL, 8'h41);
    chk({6'h00, ext_read_block, xmem_to_flash}, 8'h03);
    xmem_via_data_pointer = 1'b0;
    @(negedge sys_clk);
    chk(8'(xmem_to_flash), 8'h00);
    mpu.bus_wr(msrb_pkg::ADDR_FLASH_CTRL, 8'h02);
    rd(msrb_pkg::ADDR_FLASH_CTRL, 8'h40);
    mpu.bus_wr(msrb_pkg::ADDR_ERASE_TRIG, 8'($random(seed)));
    chk({mass_erase_start, page_erase_start, 6'h00}, 8'h80);
    mpu.bus_wr(msrb_pkg::ADDR_PAGE_ADDR, msrb_pkg::PAGE_LAST);
    rd(msrb_pkg::ADDR_PAGE_ADDR, msrb_pkg::PAGE_LAST);
    mpu.bus_wr(msrb_pkg::ADDR_ERASE_TRIG, 8'h00);
    chk({mass_erase_start, page_erase_start, 6'h00}, 8'h40);
    chk({1'b0, erase_page}, msrb_pkg::PAGE_LAST);
    rd(msrb_pkg::ADDR_PAGE_ADDR, 8'h00);
    rd(msrb_pkg::ADDR_ERASE_TRIG, 8'h00);
    preboot_active = 1'b1;
    repeat (3) @(negedge sys_clk);
    rd(msrb_pkg::ADDR_FLASH_CTRL, 8'hC0);
    preboot_active = 1'b0;
    $display("test flash done");
    for (i = 0; i < 8; i++)
    begin
      ev = 8'h01 << i;
      repeat (4) @(negedge sys_clk);
      ev = 8'h00;
      repeat (3) @(negedge sys_clk);
      rd(msrb_pkg::ADDR_EVENT_FLAGS, 8'h01 << i);
      mpu.bus_wr(msrb_pkg::ADDR_EVENT_FLAGS, 8'hFF);
      rd(msrb_pkg::ADDR_EVENT_FLAGS, 8'h01 << i);
      mpu.flag_clear(8'h01 << i);
      rd(msrb_pkg::ADDR_EVENT_FLAGS, 8'h00);
    end
    $display("test flags done");
    for (i = 0; i < 4; i++)
    begin
      v = 8'($random(seed));
      external_irq_levels = v[6:0];
      repeat (3) @(negedge sys_clk);
      rd(msrb_pkg::ADDR_INPUT_WDOG, {1'b0, v[6:0]});
    end
    mpu.bus_wr(msrb_pkg::ADDR_INPUT_WDOG, 8'h80);
    chk(8'(watchdog_restart), 8'h01);
    @(negedge sys_clk);
    chk(8'(watchdog_restart), 8'h00);
    $display("test inputs done");
    v = 8'($random(seed));
    ee_data_in = 8'($random(seed));
    ee_status_in = ~v;
    mpu.bus_wr(msrb_pkg::ADDR_EE_DATA, v);
    mpu.bus_wr(msrb_pkg::ADDR_EE_CTRL, ~v);
    mpu.bus_wr(msrb_pkg::ADDR_BANK_SEL, v);
    chk(ee_data_out, v);
    chk(ee_ctrl_out, ~v);
    chk({5'h00, flash_bank}, {5'h00, v[2:0]});
    chk(8'(ecw), 8'h01);
    rd(msrb_pkg::ADDR_EE_DATA, ee_data_in);
    rd(msrb_pkg::ADDR_EE_CTRL, ee_status_in);
    rd(msrb_pkg::ADDR_BANK_SEL, {5'h00, v[2:0]});
    $display("test eeprom done");
    results();
  end
endmodule
